// *** src/eif_pkg.sv ***
// Constants for the external interrupt input filter
package eif_pkg;
   // Control register location in the special function register space
   localparam logic [5:0] EIF_CTRL_ADDR = 6'h37;
   localparam logic [7:0] EIF_CTRL_RESET = 8'h00;
   localparam logic [7:0] EIF_CTRL_WMASK = 8'hce;
   // Control field positions
   localparam int EIF_NC_BIT = 7;
   localparam int EIF_PIN_SEL_BIT = 6;
   localparam int EIF_ES3_BIT = 3;
   localparam int EIF_ES2_BIT = 2;
   localparam int EIF_ES1_BIT = 1;
   // Channel numbering: 0 = irq zero, 1..3 = irq one..three, 4 = irq five
   localparam int EIF_NCH = 5;
   // Clock rates
   localparam int EIF_FC_HZ = 40_000_000;
   localparam int EIF_FS_HZ = 32_768;
   localparam int EIF_FS_DIV_INT = EIF_FC_HZ / EIF_FS_HZ;
   localparam logic [10:0] EIF_FS_DIV = EIF_FS_DIV_INT[10:0];
   // Noise windows in high_freq_clock periods, as printed
   localparam int EIF_Z_REJ_FC = 2;
   localparam int EIF_Z_ACC_FC = 7;
   localparam int EIF_M_REJ_FC = 7;
   localparam int EIF_M_ACC_FC = 25;
   localparam int EIF_NC1_REJ_FC = 15;
   localparam int EIF_NC1_ACC_FC = 49;
   localparam int EIF_NC0_REJ_FC = 63;
   localparam int EIF_NC0_ACC_FC = 193;
   localparam int EIF_NC_SWITCH_FC = 26;
   // Stable sample counts, placed inside each reject/accept window
   localparam int EIF_Z_N_INT = (EIF_Z_REJ_FC + EIF_Z_ACC_FC + 1) / 2;
   localparam int EIF_M_N_INT = (EIF_M_REJ_FC + EIF_M_ACC_FC) / 2;
   localparam int EIF_NC1_N_INT = (EIF_NC1_REJ_FC + EIF_NC1_ACC_FC) / 2;
   localparam int EIF_NC0_N_INT = (EIF_NC0_REJ_FC + EIF_NC0_ACC_FC) / 2;
   localparam logic [7:0] EIF_Z_N = EIF_Z_N_INT[7:0];
   localparam logic [7:0] EIF_M_N = EIF_M_N_INT[7:0];
   localparam logic [7:0] EIF_NC1_N = EIF_NC1_N_INT[7:0];
   localparam logic [7:0] EIF_NC0_N = EIF_NC0_N_INT[7:0];
   // Low speed: 1/fs rejected, 3.5/fs accepted; two low_freq_clock samples
   localparam logic [7:0] EIF_SLOW_N = 8'h02;
   // Idle level of the filtered pins after reset
   localparam logic [4:0] EIF_FILT_RESET = 5'h1f;
endpackage

// *** src/eif_filter.sv ***
// External interrupt input noise filter, edge select and control register
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: Five interrupt inputs, each with its own noise filter before the latch.
// RULE_02: Shared pin is a port bit or irq zero; port input after reset.
// RULE_03: Edge select only on inputs one to three; zero and five fall.
// RULE_04: Irq zero needs master enable, flag four, pin select; one/two use five/seven.
// RULE_05: Fast modes: inputs zero, five reject under 2/fc, accept 7/fc.
// RULE_06: Fast modes: input one rejects under 15 or 63/fc, accepts 49 or 193/fc.
// RULE_07: Fast modes: inputs two, three reject under 7/fc, accept 25/fc.
// RULE_08: Low speed: all inputs reject under 1/fs, accept 3.5/fs.
// RULE_09: Control bit 7 low gives 63/fc window, high gives 15/fc.
// RULE_10: Control bit 6 picks port or irq zero; software sets port to input.
// RULE_11: Control bits 3,2,1 pick edges of inputs 3,2,1: 0 rising, 1 falling.
// RULE_12: With pin select low, falling edges never set latch four.
// RULE_13: Clean edge sets its latch within establishment time plus 6/fs.
// RULE_14: Own drive changes on an interrupt pin raise a spurious request.
// RULE_15: Software disables interrupts while clocks or control change.
// RULE_16: New input one window applies within 26/fc of the write.
// RULE_17: Source selects route latches fourteen, fifteen away from inputs three, five.
// RULE_18: Inputs are synchronised, then filtered by counting stable samples.
module eif_filter
   import eif_pkg::*;
(
   input  wire logic       CLK,
   input  wire logic       RST_N,
   input  wire logic [5:0] SFR_ADDR,
   input  wire logic [7:0] SFR_WDATA,
   input  wire logic       SFR_WR,
   input  wire logic       SFR_RD,
   output logic      [7:0] SFR_RDATA,
   input  wire logic [4:0] EXT_IRQ_PIN,
   input  wire logic       LOW_SPEED_MODE,
   input  wire logic       MASTER_IRQ_ENABLE,
   input  wire logic       ENABLE_FLAG_FOUR,
   input  wire logic       ENABLE_FLAG_FIVE,
   input  wire logic       ENABLE_FLAG_SEVEN,
   input  wire logic       ENABLE_FLAG_FOURTEEN,
   input  wire logic       ENABLE_FLAG_FIFTEEN,
   input  wire logic       LATCH_FOURTEEN_SOURCE_SELECT,
   input  wire logic       LATCH_FIFTEEN_SOURCE_SELECT,
   output logic            SHARED_PIN_IRQ_SELECT,
   output logic [4:0]      LATCH_SET,
   output logic [4:0]      IRQ_ENABLED
);

   logic [7:0]  ctrl_q;
   logic [7:0]  rdata_q;
   logic [10:0] fs_cnt_q;
   logic        fs_tick;
   logic        sample_en;
   logic [4:0]  sync1_q;
   logic [4:0]  sync2_q;
   logic [4:0]  filt_q;
   logic [4:0]  prev_q;
   logic [7:0]  cnt_q [EIF_NCH];
   logic [7:0]  thr_w [EIF_NCH];
   logic [4:0]  fall_sel;
   logic [4:0]  edge_w;
   logic [4:0]  gate_w;
   logic [4:0]  latch_q;

   // Stable count needed by a channel in the current mode and setting
   function automatic logic [7:0] thr_of(input int ch, input logic slow, input logic nc);
      logic [7:0] t;
      t = EIF_M_N;
      if (slow)
         t = EIF_SLOW_N;
      else if (ch == 0 || ch == 4)
         t = EIF_Z_N;
      else if (ch == 1)
         t = nc ? EIF_NC1_N : EIF_NC0_N;
      return t;
   endfunction

   // Control register; reserved bits stay zero
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         ctrl_q <= EIF_CTRL_RESET; // RULE_02
      else if (SFR_WR && SFR_ADDR == EIF_CTRL_ADDR)
         ctrl_q <= SFR_WDATA & EIF_CTRL_WMASK;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         rdata_q <= 8'h00;
      else if (SFR_RD && SFR_ADDR == EIF_CTRL_ADDR)
         rdata_q <= ctrl_q;
      else
         rdata_q <= 8'h00;
   end

   assign SFR_RDATA = rdata_q;
   assign SHARED_PIN_IRQ_SELECT = ctrl_q[EIF_PIN_SEL_BIT]; // RULE_10

   // low_freq_clock sampling enable
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         fs_cnt_q <= 11'h000;
      else if (fs_cnt_q == EIF_FS_DIV - 11'h001)
         fs_cnt_q <= 11'h000;
      else
         fs_cnt_q <= fs_cnt_q + 11'h001;
   end

   assign fs_tick = (fs_cnt_q == EIF_FS_DIV - 11'h001);
   assign sample_en = LOW_SPEED_MODE ? fs_tick : 1'b1; // RULE_08

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sync1_q <= EIF_FILT_RESET;
         sync2_q <= EIF_FILT_RESET;
      end
      else if (sample_en)
      begin
         sync1_q <= EXT_IRQ_PIN; // RULE_18
         sync2_q <= sync1_q;
      end
   end

   // Pin level includes the device's own drive, so output changes show up as edges
   genvar g;
   generate
      for (g = 0; g < EIF_NCH; g++)
      begin : g_ch
         assign thr_w[g] = thr_of(g, LOW_SPEED_MODE, ctrl_q[EIF_NC_BIT]); // RULE_09 RULE_16

         always_ff @(posedge CLK or negedge RST_N)
         begin
            if (!RST_N)
            begin
               cnt_q[g] <= 8'h00;
               filt_q[g] <= EIF_FILT_RESET[g];
            end
            else if (sample_en)
            begin
               if (sync2_q[g] == filt_q[g])
                  cnt_q[g] <= 8'h00;
               else if (cnt_q[g] + 8'h01 >= thr_w[g])
               begin
                  filt_q[g] <= sync2_q[g]; // RULE_01 RULE_05 RULE_06 RULE_07
                  cnt_q[g] <= 8'h00;
               end
               else
                  cnt_q[g] <= cnt_q[g] + 8'h01;
            end
         end
      end
   endgenerate

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         prev_q <= EIF_FILT_RESET;
      else
         prev_q <= filt_q;
   end

   // Zero and five are falling only
   assign fall_sel = {1'b1, ctrl_q[EIF_ES3_BIT], ctrl_q[EIF_ES2_BIT],
                      ctrl_q[EIF_ES1_BIT], 1'b1}; // RULE_03 RULE_11
   assign edge_w = (prev_q & ~filt_q & fall_sel) | (~prev_q & filt_q & ~fall_sel); // RULE_14

   assign gate_w = {~LATCH_FIFTEEN_SOURCE_SELECT, ~LATCH_FOURTEEN_SOURCE_SELECT,
                    2'b11, ctrl_q[EIF_PIN_SEL_BIT]}; // RULE_12 RULE_17

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         latch_q <= 5'h00;
      else
         latch_q <= edge_w & gate_w; // RULE_13
   end

   assign LATCH_SET = latch_q;

   assign IRQ_ENABLED[0] = MASTER_IRQ_ENABLE & ENABLE_FLAG_FOUR
                           & ctrl_q[EIF_PIN_SEL_BIT]; // RULE_04
   assign IRQ_ENABLED[1] = MASTER_IRQ_ENABLE & ENABLE_FLAG_FIVE; // RULE_04
   assign IRQ_ENABLED[2] = MASTER_IRQ_ENABLE & ENABLE_FLAG_SEVEN; // RULE_04
   assign IRQ_ENABLED[3] = MASTER_IRQ_ENABLE & ENABLE_FLAG_FOURTEEN
                           & ~LATCH_FOURTEEN_SOURCE_SELECT; // RULE_17
   assign IRQ_ENABLED[4] = MASTER_IRQ_ENABLE & ENABLE_FLAG_FIFTEEN
                           & ~LATCH_FIFTEEN_SOURCE_SELECT; // RULE_17

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_fall0;
      $fell(filt_q[0]) && ctrl_q[EIF_PIN_SEL_BIT];
   endsequence

   sequence s_rise1;
      $rose(filt_q[1]) && !ctrl_q[EIF_ES1_BIT];
   endsequence

   property p_ext_irq_zero_blocked;
      !ctrl_q[EIF_PIN_SEL_BIT] |=> !LATCH_SET[0];
   endproperty
   a_ext_irq_zero_blocked: assert property (p_ext_irq_zero_blocked) else $error("latch four set in port mode"); // RULE_12

   property p_fast_zero;
      !LOW_SPEED_MODE && $changed(filt_q[0]) |-> $past(cnt_q[0]) == EIF_Z_N - 8'h01;
   endproperty
   a_fast_zero: assert property (p_fast_zero) else $error("irq zero window wrong"); // RULE_05

   property p_one_window;
      !LOW_SPEED_MODE && $changed(filt_q[1]) |-> $past(cnt_q[1]) + 8'h01 >= $past(thr_w[1]);
   endproperty
   a_one_window: assert property (p_one_window) else $error("irq one accepted early"); // RULE_06

   property p_two_window;
      !LOW_SPEED_MODE && $changed(filt_q[2]) |-> $past(cnt_q[2]) == EIF_M_N - 8'h01;
   endproperty
   a_two_window: assert property (p_two_window) else $error("irq two window wrong"); // RULE_07

   property p_slow_window;
      LOW_SPEED_MODE && $past(LOW_SPEED_MODE) && $changed(filt_q[3])
         |-> $past(cnt_q[3]) == EIF_SLOW_N - 8'h01;
   endproperty
   a_slow_window: assert property (p_slow_window) else $error("slow window wrong"); // RULE_08

   property p_five_no_rise;
      $rose(filt_q[4]) |=> !LATCH_SET[4];
   endproperty
   a_five_no_rise: assert property (p_five_no_rise) else $error("irq five took rising edge"); // RULE_03

   property p_zero_latency;
      s_fall0 |=> LATCH_SET[0];
   endproperty
   a_zero_latency: assert property (p_zero_latency) else $error("latch four not set"); // RULE_13

   property p_one_rising;
      s_rise1 |=> LATCH_SET[1];
   endproperty
   a_one_rising: assert property (p_one_rising) else $error("irq one rising edge lost"); // RULE_11

   property p_src14;
      LATCH_SET[3] |-> !$past(LATCH_FOURTEEN_SOURCE_SELECT);
   endproperty
   a_src14: assert property (p_src14) else $error("irq three routed while timer selected"); // RULE_17

   property p_nc_switch;
      SFR_WR && SFR_ADDR == EIF_CTRL_ADDR && !LOW_SPEED_MODE ##1 !LOW_SPEED_MODE
         |-> thr_w[1] == ($past(SFR_WDATA[EIF_NC_BIT]) ? EIF_NC1_N : EIF_NC0_N);
   endproperty
   a_nc_switch: assert property (p_nc_switch) else $error("irq one window not updated"); // RULE_16

   property p_enable0;
      IRQ_ENABLED[0] |-> SHARED_PIN_IRQ_SELECT && MASTER_IRQ_ENABLE && ENABLE_FLAG_FOUR;
   endproperty
   a_enable0: assert property (p_enable0) else $error("irq zero enabled in port mode"); // RULE_04

   property p_rdata_echo;
      SFR_RD && SFR_ADDR == EIF_CTRL_ADDR |=> SFR_RDATA == $past(ctrl_q);
   endproperty
   a_rdata_echo: assert property (p_rdata_echo) else $error("read data wrong"); // RULE_10

   property p_rdata_idle;
      !(SFR_RD && SFR_ADDR == EIF_CTRL_ADDR) |=> SFR_RDATA == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data stuck"); // RULE_10

   property p_reserved_zero;
      (ctrl_q & ~EIF_CTRL_WMASK) == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit"); // RULE_02

   property p_latch_pulse;
      (LATCH_SET & $past(LATCH_SET)) == 5'h00;
   endproperty
   a_latch_pulse: assert property (p_latch_pulse) else $error("pulse too long"); // RULE_01

   property p_fast_five;
      !LOW_SPEED_MODE && $changed(filt_q[4]) |-> $past(cnt_q[4]) == EIF_Z_N - 8'h01;
   endproperty
   a_fast_five: assert property (p_fast_five) else $error("irq five window wrong"); // RULE_05

   property p_three_window;
      !LOW_SPEED_MODE && $changed(filt_q[3]) |-> $past(cnt_q[3]) == EIF_M_N - 8'h01;
   endproperty
   a_three_window: assert property (p_three_window) else $error("three window"); // RULE_07

   property p_one_wide;
      !LOW_SPEED_MODE && $changed(filt_q[1]) && !$past(ctrl_q[EIF_NC_BIT])
         |-> $past(cnt_q[1]) == EIF_NC0_N - 8'h01;
   endproperty
   a_one_wide: assert property (p_one_wide) else $error("irq one wide window wrong"); // RULE_09

   sequence s_fall1;
      $fell(filt_q[1]) && !ctrl_q[EIF_ES1_BIT];
   endsequence

   property p_one_fall;
      s_fall1 |=> !LATCH_SET[1];
   endproperty
   a_one_fall: assert property (p_one_fall) else $error("irq one wrong edge"); // RULE_11

   property p_slow_hold;
      LOW_SPEED_MODE && !fs_tick |=> $stable(sync2_q);
   endproperty
   a_slow_hold: assert property (p_slow_hold) else $error("slow sampling off tick"); // RULE_08

   property p_src_off;
      LATCH_FOURTEEN_SOURCE_SELECT |-> !IRQ_ENABLED[3];
   endproperty
   a_src_off: assert property (p_src_off) else $error("irq three enabled for timer"); // RULE_17

endmodule

// *** test/eif_board.sv ***
// Board-side model that drives the five interrupt pins
`timescale 1ns/1ps
module eif_board
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        go,
   input  wire logic [4:0]  mask,
   input  wire logic [15:0] len,
   output logic      [4:0]  pin
);
   logic [15:0] cnt_q;
   logic [4:0]  hold_q;
   // Pins idle high; go toggles masked pins for len cycles, len 0 keeps the new level
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin <= 5'h1f;
         cnt_q <= 16'h0000;
         hold_q <= 5'h00;
      end
      else if (go)
      begin
         pin <= pin ^ mask;
         cnt_q <= len;
         hold_q <= mask;
      end
      else if (cnt_q != 16'h0000)
      begin
         cnt_q <= cnt_q - 16'h0001;
         if (cnt_q == 16'h0001)
            pin <= pin ^ hold_q;
      end
   end
endmodule

// *** test/testbench.sv ***
// Register and pin-filter regression for the interrupt input filter
`timescale 1ns/1ps
module testbench;
   import eif_pkg::*;
   logic        clk, rst_n, sfr_wr, sfr_rd, low_spd, mie, go, src14, src15, clr;
   logic [5:0]  sfr_addr;
   logic [7:0]  sfr_wdata, sfr_rdata;
   logic [4:0]  pins, latch_set, irq_en, seen, mask, ef;
   logic        pin_sel;
   logic [15:0] len;
   int          miscompares, comparisons, cycles, tail;
   eif_board board_u (.clk(clk), .rst_n(rst_n), .go(go), .mask(mask), .len(len), .pin(pins));
   eif_filter dut_u (.CLK(clk), .RST_N(rst_n), .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata),
      .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_RDATA(sfr_rdata), .EXT_IRQ_PIN(pins),
      .LOW_SPEED_MODE(low_spd), .MASTER_IRQ_ENABLE(mie), .ENABLE_FLAG_FOUR(ef[0]),
      .ENABLE_FLAG_FIVE(ef[1]), .ENABLE_FLAG_SEVEN(ef[2]), .ENABLE_FLAG_FOURTEEN(ef[3]),
      .ENABLE_FLAG_FIFTEEN(ef[4]), .LATCH_FOURTEEN_SOURCE_SELECT(src14),
      .LATCH_FIFTEEN_SOURCE_SELECT(src15), .SHARED_PIN_IRQ_SELECT(pin_sel),
      .LATCH_SET(latch_set), .IRQ_ENABLED(irq_en));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Latch pulses seen since the last clear
   always @(posedge clk)
   begin
      seen <= clr ? 5'h00 : (seen | latch_set);
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         miscompares = miscompares + 1;
         results();
      end
   end
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
         miscompares = miscompares + 1;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_vec(input logic [4:0] got, input logic [4:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
         miscompares = miscompares + 1;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      @(posedge clk);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1;
      chk_reg(sfr_rdata, exp);
   endtask
   // Toggle masked pins for n cycles (0 keeps the new level) and check latch pulses
   task automatic shot(input logic [4:0] m, input logic [15:0] n, input logic [4:0] exp);
      @(posedge clk);
      clr <= 1'b1;
      go <= 1'b1;
      mask <= m;
      len <= n;
      @(posedge clk);
      clr <= 1'b0;
      go <= 1'b0;
      repeat (int'(n) + tail) @(posedge clk);
      chk_vec(seen, exp);
   endtask
   task automatic results();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      {rst_n, sfr_wr, sfr_rd, low_spd, go, src14, src15} = 7'h00;
      {sfr_addr, sfr_wdata, mask, len, seen, clr} = '0;
      ef = 5'h1f;
      mie = 1'b1;
      miscompares = 0;
      comparisons = 0;
      tail = 300;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd(EIF_CTRL_ADDR, 8'h00);
      chk_vec({4'h0, pin_sel}, 5'h00);
      wr(EIF_CTRL_ADDR, 8'hff);
      rd(EIF_CTRL_ADDR, 8'hce);
      wr(6'h20, 8'h55);
      rd(6'h20, 8'h00);
      rd(EIF_CTRL_ADDR, 8'hce);
      chk_vec(irq_en, 5'h1f);
      $display("test registers done");
      shot(5'h1f, 16'd1, 5'h00);
      shot(5'h0e, 16'd6, 5'h00);
      shot(5'h02, 16'd14, 5'h00);
      shot(5'h11, 16'd7, 5'h11);
      shot(5'h0c, 16'd25, 5'h0c);
      shot(5'h02, 16'd49, 5'h02);
      wr(EIF_CTRL_ADDR, 8'h4e);
      shot(5'h02, 16'd62, 5'h00);
      shot(5'h02, 16'd193, 5'h02);
      $display("test windows done");
      src14 <= 1'b1;
      src15 <= 1'b1;
      shot(5'h18, 16'd25, 5'h00);
      chk_vec(irq_en, 5'h07);
      src14 <= 1'b0;
      src15 <= 1'b0;
      mie <= 1'b0;
      wr(EIF_CTRL_ADDR, 8'h8e);
      chk_vec(irq_en, 5'h00);
      mie <= 1'b1;
      shot(5'h01, 16'd7, 5'h00);
      chk_vec(irq_en, 5'h1e);
      ef <= 5'h15;
      @(posedge clk);
      chk_vec(irq_en, 5'h14);
      ef <= 5'h1f;
      $display("test gating done");
      shot(5'h1f, 16'd0, 5'h1e);
      shot(5'h1f, 16'd0, 5'h00);
      wr(EIF_CTRL_ADDR, 8'h80);
      shot(5'h1e, 16'd0, 5'h10);
      shot(5'h1e, 16'd0, 5'h0e);
      $display("test edges done");
      mie <= 1'b0;
      wr(EIF_CTRL_ADDR, 8'h40);
      low_spd <= 1'b1;
      repeat (3000) @(posedge clk);
      tail = 7000;
      shot(5'h1f, 16'd600, 5'h00);
      shot(5'h1f, 16'd4300, 5'h1f);
      $display("test slow done");
      results();
   end
endmodule
